// file: logic/scsc_pkg.sv
// Package of constants for the system clock source control block
package scsc_pkg;

   // ----------------------------------------
   // Register map (word aligned, APB)
   // ----------------------------------------
   localparam logic [11:0] ADDR_MODE     = 12'h000;
   localparam logic [11:0] ADDR_OSC_CTRL = 12'h004;
   localparam logic [11:0] ADDR_STATUS   = 12'h008;

   // ----------------------------------------
   // Mode register fields and reset value
   // ----------------------------------------
   localparam int          MODE_SRC_LSB  = 0;
   localparam int          MODE_DIV_LSB  = 2;
   localparam logic [3:0]  MODE_RESET    = 4'hc;

   // ----------------------------------------
   // Oscillator control fields and reset value
   // ----------------------------------------
   localparam int          OSC_FAST_BIT  = 0;
   localparam int          OSC_MAIN_BIT  = 1;
   localparam int          OSC_SUB_BIT   = 2;
   localparam int          OSC_SLOW_BIT  = 3;
   localparam logic [3:0]  OSC_RESET     = 4'h8;

   // ----------------------------------------
   // Source and division encodings
   // ----------------------------------------
   typedef enum logic [1:0] {
      SRC_FAST = 2'h0,
      SRC_MAIN = 2'h1,
      SRC_SUB  = 2'h2,
      SRC_SLOW = 2'h3
   } scsc_src_t;

   typedef enum logic [1:0] {
      DIV_1 = 2'h0,
      DIV_2 = 2'h1,
      DIV_4 = 2'h2,
      DIV_8 = 2'h3
   } scsc_div_t;

endpackage

// file: logic/scsc_top.sv
// System clock source selection, division and oscillator enables
//
// What this block does
// - After reset the system clock comes from the fast internal oscillator.
// - After reset the main clock oscillator is enabled.
// - After reset the slow internal oscillator stays disabled until software enables it.
// - Oscillator enables and source choice follow only the two control registers.
// - Sub-clock stop bit set stops the sub-clock and frees its pins as ports.
// - Mode register holds both source choice and division ratio.
// - Mode register loads from the APB write data by a write to the mode offset only.
// - Read-mode operation returns the current mode register contents.
// - Upper mode bits divide by 1, 2, 4 or 8.
// - Lower mode bits pick fast, main, sub or slow source.
// - A stopped oscillator cannot be selected as system clock source.
// - The oscillator feeding the system clock cannot be stopped.
//
// Registers: mode at 0x000, oscillator stop control at 0x004, status at 0x008.
// Oscillators arrive as clock enables in the sys_clk domain, so no synchroniser.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module scsc_top
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   // Oscillator sources, already running on sys_clk as enables
   input  wire logic [3:0]  osc_tick,
   // Clock control outputs
   output logic [3:0]       osc_enable,
   output logic [1:0]       sys_clk_source,
   output logic [1:0]       sys_clk_divide,
   output logic             sys_clk_tick,
   output logic             sub_pins_as_port
);

   // ----------------------------------------
   // Decoding helpers
   // ----------------------------------------
   // Enable bit of the oscillator behind a source code
   function automatic logic [3:0] src_onehot(input logic [1:0] src);
      src_onehot = 4'h1 << src;
   endfunction

   // Count bits that take part in the wrap for a division code
   function automatic logic [2:0] div_mask(input logic [1:0] dv);
      case (dv)
         scsc_pkg::DIV_1: div_mask = 3'h0;
         scsc_pkg::DIV_2: div_mask = 3'h1;
         scsc_pkg::DIV_4: div_mask = 3'h3;
         default:         div_mask = 3'h7;
      endcase
   endfunction

   // Source and ratio fields of a mode word
   function automatic logic [1:0] mode_src(input logic [3:0] mode);
      mode_src = mode[scsc_pkg::MODE_SRC_LSB +: 2];
   endfunction

   function automatic logic [1:0] mode_div(input logic [3:0] mode);
      mode_div = mode[scsc_pkg::MODE_DIV_LSB +: 2];
   endfunction

   // A source may be chosen only while its oscillator runs
   function automatic logic src_allowed(input logic [3:0] stop, input logic [1:0] src);
      src_allowed = ~stop[src];
   endfunction

   // Read word for one register offset; unmapped offsets read zero
   function automatic logic [31:0] rd_word(input logic [11:0] addr, input logic [3:0] mode,
                                           input logic [3:0] stop, input logic [3:0] ticks);
      rd_word = 32'h0;
      if (addr == scsc_pkg::ADDR_MODE)
         rd_word = {28'h0, mode};
      else if (addr == scsc_pkg::ADDR_OSC_CTRL)
         rd_word = {28'h0, stop};
      else if (addr == scsc_pkg::ADDR_STATUS)
         rd_word = {24'h0, ticks, ~stop};
   endfunction

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   logic        wr_acc;
   logic        hit_mode;
   logic        hit_osc;
   logic        hit_stat;
   logic        hit_any;

   assign wr_acc   = psel & penable & pwrite;
   assign hit_mode = (paddr == scsc_pkg::ADDR_MODE);
   assign hit_osc  = (paddr == scsc_pkg::ADDR_OSC_CTRL);
   assign hit_stat = (paddr == scsc_pkg::ADDR_STATUS);
   // Status is read-only, so a write to it is refused like a miss
   assign hit_any  = hit_mode | hit_osc | (hit_stat & ~pwrite);
   // Zero wait states; unmapped addresses answer with an error
   assign pready   = 1'b1;
   assign pslverr  = psel & penable & ~hit_any;

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   logic [3:0]  mode_ff;
   logic [3:0]  nxt_mode;
   logic [3:0]  osc_stop_ff;
   logic [3:0]  nxt_osc_stop;
   logic [1:0]  cur_src;
   logic [1:0]  cur_div;
   logic [1:0]  req_src;
   logic [1:0]  req_div;
   logic [3:0]  keep_running;
   logic        osc_wr;
   logic        mode_wr;

   // Only the two control registers change enables or source
   assign mode_wr = wr_acc & hit_mode;
   assign osc_wr  = wr_acc & hit_osc;
   assign cur_src = mode_src(mode_ff);
   assign cur_div = mode_div(mode_ff);
   assign req_src = mode_src(pwdata[3:0]);
   assign req_div = mode_div(pwdata[3:0]);

   // ----------------------------------------
   // Mode register: source and division
   // ----------------------------------------
   always_comb
   begin
      nxt_mode = mode_ff;
      if (mode_wr)
      begin
         nxt_mode[scsc_pkg::MODE_DIV_LSB +: 2] = req_div;
         // A stopped source is refused and the old source stays, since
         // switching to a dead oscillator would freeze the system clock
         if (src_allowed(osc_stop_ff, req_src))
         begin
            nxt_mode[scsc_pkg::MODE_SRC_LSB +: 2] = req_src;
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         mode_ff <= scsc_pkg::MODE_RESET;
      end
      else
      begin
         mode_ff <= nxt_mode;
      end
   end

   // ----------------------------------------
   // Oscillator stop register
   // ----------------------------------------
   // The oscillator feeding the system clock keeps running whatever is
   // written; software must move the source away before stopping it
   assign keep_running = src_onehot(cur_src);

   for (genvar i = 0; i < 4; i++)
   begin : g_stop
      assign nxt_osc_stop[i] = osc_wr ? (pwdata[i] & ~keep_running[i]) : osc_stop_ff[i];
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         osc_stop_ff <= scsc_pkg::OSC_RESET;
      end
      else
      begin
         osc_stop_ff <= nxt_osc_stop;
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   logic        setup_rd;
   logic        in_access;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;

   // Read data is chosen in the setup cycle and stands from a flip-flop
   // through the access phase, so no wait state is needed
   assign setup_rd  = psel & ~penable & ~pwrite;
   assign in_access = psel & penable;

   always_comb
   begin
      nxt_prdata = prdata_ff;
      if (setup_rd)
      begin
         nxt_prdata = rd_word(paddr, mode_ff, osc_stop_ff, osc_tick);
      end
      else if (!in_access)
      begin
         // Outside a transfer the bus reads zero
         nxt_prdata = 32'h0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         prdata_ff <= 32'h0;
      end
      else
      begin
         prdata_ff <= nxt_prdata;
      end
   end

   assign prdata = prdata_ff;

   // ----------------------------------------
   // Source selection and divider
   // ----------------------------------------
   logic [2:0]  div_cnt_ff;
   logic [2:0]  nxt_div_cnt;
   logic        tick_ff;
   logic        nxt_tick;
   logic        src_tick;
   logic [2:0]  cur_mask;
   logic        cnt_wrap;

   // A ratio change keeps the low count bits, so the first divided period
   // after it may be short; a glitch-free switch would cost a full resync
   assign src_tick = osc_tick[cur_src];
   assign cur_mask = div_mask(cur_div);
   assign cnt_wrap = (div_cnt_ff & cur_mask) == 3'h0;

   always_comb
   begin
      nxt_div_cnt = div_cnt_ff;
      if (src_tick)
      begin
         nxt_div_cnt = (div_cnt_ff + 3'h1) & cur_mask;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         div_cnt_ff <= 3'h0;
      end
      else
      begin
         div_cnt_ff <= nxt_div_cnt;
      end
   end

   // ----------------------------------------
   // Divided tick
   // ----------------------------------------
   // One output tick per wrap of the count
   always_comb
   begin
      nxt_tick = 1'b0;
      if (src_tick && cnt_wrap)
      begin
         nxt_tick = 1'b1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         tick_ff <= 1'b0;
      end
      else
      begin
         tick_ff <= nxt_tick;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Enables are the stop bits inverted
   for (genvar j = 0; j < 4; j++)
   begin : g_enable
      assign osc_enable[j] = ~osc_stop_ff[j];
   end

   assign sys_clk_source   = cur_src;
   assign sys_clk_divide   = cur_div;
   assign sys_clk_tick     = tick_ff;
   // The shared sub-clock pins serve as ports exactly while it is stopped
   assign sub_pins_as_port = osc_stop_ff[scsc_pkg::OSC_SUB_BIT];

endmodule

`default_nettype wire

// file: test/scsc_top_monitor.sv
// Port checker for the clock control block
`timescale 1ns/100ps
`default_nettype none
module scsc_top_monitor
(
   // Clock, reset and bus
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   // Clock control
   input wire logic [3:0]  osc_tick,
   input wire logic [3:0]  osc_enable,
   input wire logic [1:0]  sys_clk_source,
   input wire logic [1:0]  sys_clk_divide,
   input wire logic        sys_clk_tick,
   input wire logic        sub_pins_as_port
);
   logic       acc;
   logic [1:0] wr_div;
   assign acc = psel && penable;
   assign wr_div = pwdata[3:2];
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   AST_RST_FAST: assert property ($rose(rst_n) |-> sys_clk_source == 2'h0)
      else $error("source not fast after reset");
   AST_RST_MAIN: assert property ($rose(rst_n) |-> osc_enable[1])
      else $error("main oscillator off after reset");
   AST_RST_SLOW: assert property ($rose(rst_n) |-> !osc_enable[3])
      else $error("slow oscillator on after reset");
   AST_SUB_PINS: assert property (sub_pins_as_port != osc_enable[2])
      else $error("sub pins and sub oscillator disagree");
   AST_SRC_RUNS: assert property (osc_enable[sys_clk_source])
      else $error("selected source is stopped");
   AST_MODE_WR: assert property (acc && pwrite && paddr == 12'h000 |=> sys_clk_divide == $past(wr_div))
      else $error("divide not loaded by mode write");
   AST_MODE_RD: assert property (acc && !pwrite && paddr == 12'h000 |->
      prdata == {28'h0, sys_clk_divide, sys_clk_source})
      else $error("mode read data wrong");
   AST_QUIET: assert property (!(acc && pwrite) |=> $stable(sys_clk_source) && $stable(osc_enable))
      else $error("clock control changed without a write");
   AST_DIV_ONE: assert property (!acc && sys_clk_divide == 2'h0 && osc_tick[sys_clk_source] |=> sys_clk_tick)
      else $error("undivided tick missing");
endmodule
bind scsc_top scsc_top_monitor mon_u (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .osc_tick, .osc_enable, .sys_clk_source, .sys_clk_divide, .sys_clk_tick, .sub_pins_as_port);
`default_nettype wire

// file: test/scsc_top_bench.sv
// Directed bench for the clock control block
`timescale 1ns/100ps
`default_nettype none
module scsc_top_bench;
   logic        sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0]  osc_tick = 4'h0, osc_enable;
   logic [1:0]  sys_clk_source, sys_clk_divide;
   logic        pready, pslverr, sys_clk_tick, sub_pins_as_port, err;
   int          mismatches = 0, tests_run = 0, cyc = 0, ticks = 0;
   always #50 sys_clk = ~sys_clk;
   scsc_top dut_u (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
      .osc_tick, .osc_enable, .sys_clk_source, .sys_clk_divide, .sys_clk_tick, .sub_pins_as_port);
   task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         $display("ERROR %s expected %h seen %h", n, exp, got);
         mismatches++;
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic end_sim;
      if (mismatches == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Hang guard, far above the roughly 140 cycles the sequence needs
   always @(posedge sys_clk)
   begin
      cyc++;
      if (sys_clk_tick === 1'b1)
         ticks++;
      if (cyc == 3000)
      begin
         mismatches++;
         end_sim;
      end
   end
   initial
   begin
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      bus(1'b0, 12'h000, 32'h0);
      chk("mode", rd, 32'hc);
      chk("mode_err", err, 1'b0);
      osc_tick <= 4'ha;
      bus(1'b0, 12'h008, 32'h0);
      osc_tick <= 4'h0;
      chk("status", rd[7:0], 8'ha7);
      // Sixteen source ticks give a whole number of divided ticks at any phase
      for (int d = 0; d < 4; d++)
      begin
         bus(1'b1, 12'h000, d << 2);
         ticks = 0;
         osc_tick <= 4'h1;
         repeat (16) @(posedge sys_clk);
         osc_tick <= 4'h0;
         repeat (3) @(posedge sys_clk);
         chk("ticks", ticks, 16 >> d);
      end
      bus(1'b1, 12'h004, 32'h0);
      for (int s = 0; s < 4; s++)
      begin
         bus(1'b1, 12'h000, s);
         chk("source", sys_clk_source, s);
      end
      bus(1'b1, 12'h004, 32'h8);
      chk("enable", osc_enable, 4'hf);
      bus(1'b1, 12'h000, 32'h0);
      bus(1'b1, 12'h004, 32'h6);
      chk("pins", {sub_pins_as_port, osc_enable}, 5'h19);
      bus(1'b0, 12'h004, 32'h0);
      chk("stop", rd, 32'h6);
      bus(1'b1, 12'h000, 32'h5);
      chk("refused", {sys_clk_divide, sys_clk_source}, 4'h4);
      bus(1'b0, 12'h00c, 32'h0);
      chk("unmapped", err, 1'b1);
      bus(1'b1, 12'h008, 32'hf);
      chk("readonly", {err, osc_enable}, 5'h19);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      chk("reset", {sys_clk_divide, sys_clk_source, osc_enable}, 8'hc7);
      end_sim;
   end
endmodule
`default_nettype wire
